/* File: logic/dcg_cfg.svh */
// command codes, flash-control constants and gate constants for the debug command gate
`ifndef DCG_CFG_SVH
`define DCG_CFG_SVH

// ==================================================
// command bytes
`define DCG_CMD_REV       8'h00
`define DCG_CMD_STAT      8'h02
`define DCG_CMD_RTC       8'h03
`define DCG_CMD_WR_CTL    8'h04
`define DCG_CMD_RD_CTL    8'h05
`define DCG_CMD_WR_PC     8'h06
`define DCG_CMD_RD_PC     8'h07
`define DCG_CMD_WR_REG    8'h08
`define DCG_CMD_RD_REG    8'h09
`define DCG_CMD_WR_PMEM   8'h0A
`define DCG_CMD_RD_PMEM   8'h0B
`define DCG_CMD_WR_DMEM   8'h0C
`define DCG_CMD_RD_DMEM   8'h0D
`define DCG_CMD_CRC       8'h0E
`define DCG_CMD_STEP      8'h10
`define DCG_CMD_STUFF     8'h11
`define DCG_CMD_EXEC      8'h12

// ==================================================
// reply fill and control-byte fields
`define DCG_FILL_BYTE     8'hFF
`define DCG_HALT_POS      7

// ==================================================
// flash control register address and mass-erase value (plain defaults)
`define DCG_FLASH_CTL_ADDR 12'hFF8
`define DCG_MASS_ERASE     8'h63

`endif

/* File: logic/dcg_gate.sv */
// debug command decoder and permission gate
`timescale 1ns/100ps
`include "dcg_cfg.svh"

module dcg_gate
  import dcg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // byte stream from the serial framer
  input  wire logic        byte_valid,
  input  wire logic        byte_is_cmd,
  input  wire logic [7:0]  byte_data,
  input  wire logic [11:0] reg_addr,
  input  wire logic        cmd_end,
  // device state
  input  wire logic        debug_halt_bit,
  input  wire logic        read_protection_option,
  // decode results
  output logic             cmd_taken,
  output logic [7:0]       cmd_code,
  output logic             cmd_allowed,
  output logic             cmd_reserved,
  output logic             busy,
  output logic             reply_fill,
  // gated payload and processor control
  output logic             pay_wr,
  output logic [7:0]       pay_data,
  output logic             cpu_step
);

  // ==================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  // async assert, synchronous release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==================================================
  // decode and permission
  logic      dec_defined;
  logic      dec_normal_ok;
  logic      dec_rp_block;
  dcg_kind_t dec_kind;

  // classify the incoming command byte
  always_comb begin
    dec_defined   = 1'b1;
    dec_normal_ok = 1'b0;
    dec_rp_block  = 1'b0;
    dec_kind      = DCG_KIND_READ;
    case (byte_data)
      `DCG_CMD_REV, `DCG_CMD_STAT, `DCG_CMD_RD_CTL: begin
        dec_normal_ok = 1'b1;
      end
      `DCG_CMD_WR_CTL: begin
        dec_normal_ok = 1'b1;
        dec_kind      = DCG_KIND_WRITE;
      end
      `DCG_CMD_RTC, `DCG_CMD_CRC: begin
      end
      `DCG_CMD_RD_PC, `DCG_CMD_RD_REG, `DCG_CMD_RD_PMEM, `DCG_CMD_RD_DMEM: begin
        dec_rp_block = 1'b1;
      end
      `DCG_CMD_WR_PC, `DCG_CMD_WR_PMEM, `DCG_CMD_WR_DMEM: begin
        dec_rp_block = 1'b1;
        dec_kind     = DCG_KIND_WRITE;
      end
      `DCG_CMD_WR_REG: begin
        dec_kind = DCG_KIND_WRITE; // filtered per byte under protection
      end
      `DCG_CMD_STEP, `DCG_CMD_STUFF, `DCG_CMD_EXEC: begin
        dec_rp_block = 1'b1;
        dec_kind     = DCG_KIND_CPU;
      end
      default: begin
        dec_defined = 1'b0;
      end
    endcase
  end

  logic dec_allowed;
  // normal mode lets the small subset through, debug mode all unless protected
  assign dec_allowed = debug_halt_bit ? !(read_protection_option && dec_rp_block)
                                      : dec_normal_ok;

  // ==================================================
  // command state
  dcg_state_t state;
  dcg_state_t next_state;
  dcg_kind_t  kind;
  dcg_kind_t  next_kind;
  logic [7:0] next_cmd_code;
  logic       next_cmd_allowed;
  logic       next_cmd_taken;
  logic       next_cmd_reserved;
  logic       next_reply_fill;
  logic       next_cpu_step;
  logic       next_busy;
  logic       cmd_start;

  // a command byte is taken only while idle; stray bytes in idle are dropped
  assign cmd_start = (state == DCG_IDLE) && byte_valid && byte_is_cmd;

  // next values for the command tracking
  always_comb begin
    next_state        = state;
    next_kind         = kind;
    next_cmd_code     = cmd_code;
    next_cmd_allowed  = cmd_allowed;
    next_reply_fill   = reply_fill;
    next_cmd_taken    = 1'b0;
    next_cmd_reserved = 1'b0;
    next_cpu_step     = 1'b0;
    if (cmd_start) begin
      if (dec_defined) begin
        next_state       = DCG_ACTIVE;
        next_kind        = dec_kind;
        next_cmd_code    = byte_data;
        next_cmd_allowed = dec_allowed;
        next_cmd_taken   = 1'b1;
        next_reply_fill  = !dec_allowed && (dec_kind == DCG_KIND_READ);
        next_cpu_step    = dec_allowed && (byte_data == `DCG_CMD_STEP);
      end else begin
        next_cmd_reserved = 1'b1;
      end
    end else if (state == DCG_ACTIVE && cmd_end) begin
      next_state      = DCG_IDLE;
      next_reply_fill = 1'b0;
    end
    next_busy = (next_state == DCG_ACTIVE); // registered so the pin never glitches on decode
  end

  // register the command tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= DCG_IDLE;
      kind         <= DCG_KIND_READ;
      cmd_code     <= 8'h00;
      cmd_allowed  <= 1'b0;
      cmd_taken    <= 1'b0;
      cmd_reserved <= 1'b0;
      reply_fill   <= 1'b0;
      cpu_step     <= 1'b0;
      busy         <= 1'b0;
    end else begin
      state        <= next_state;
      kind         <= next_kind;
      cmd_code     <= next_cmd_code;
      cmd_allowed  <= next_cmd_allowed;
      cmd_taken    <= next_cmd_taken;
      cmd_reserved <= next_cmd_reserved;
      reply_fill   <= next_reply_fill;
      cpu_step     <= next_cpu_step;
      busy         <= next_busy;
    end
  end

  // ==================================================
  // payload gate
  logic       pay_in;
  logic       pay_ok;
  logic       next_pay_wr;
  logic [7:0] next_pay_data;
  logic       rp_on;

  // payload bytes are always consumed; only permitted ones go further
  assign pay_in = busy && byte_valid && !byte_is_cmd && (kind != DCG_KIND_READ);
  assign rp_on  = read_protection_option && debug_halt_bit;

  // per-byte permission and control-byte shaping
  always_comb begin
    pay_ok        = cmd_allowed;
    next_pay_data = byte_data;
    if (rp_on && cmd_code == `DCG_CMD_WR_REG) begin
      // protected register write reaches only flash control, and only mass erase
      pay_ok = cmd_allowed && (reg_addr == `DCG_FLASH_CTL_ADDR)
               && (byte_data == `DCG_MASS_ERASE);
    end
    if (read_protection_option && cmd_code == `DCG_CMD_WR_CTL) begin
      // halt bit can be raised but a zero leaves it as it is
      next_pay_data[`DCG_HALT_POS] = byte_data[`DCG_HALT_POS] | debug_halt_bit;
    end
    next_pay_wr = pay_in && pay_ok;
  end

  // register the gated payload
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pay_wr   <= 1'b0;
      pay_data <= 8'h00;
    end else begin
      pay_wr   <= next_pay_wr;
      pay_data <= next_pay_data;
    end
  end

  // ==================================================
  // checks
  property p_normal_subset;
    @(posedge clk) disable iff (!rst_n)
      (cmd_start && !debug_halt_bit && byte_data == `DCG_CMD_WR_PC)
        |=> (cmd_taken && !cmd_allowed);
  endproperty
  a_normal_subset: assert property (p_normal_subset) else $error("pc write outside debug");

  property p_normal_ctl;
    @(posedge clk) disable iff (!rst_n)
      (cmd_start && byte_data == `DCG_CMD_WR_CTL) |=> cmd_allowed;
  endproperty
  a_normal_ctl: assert property (p_normal_ctl) else $error("control write refused");

  property p_debug_all;
    @(posedge clk) disable iff (!rst_n)
      (cmd_start && dec_defined && debug_halt_bit && !read_protection_option) |=> cmd_allowed;
  endproperty
  a_debug_all: assert property (p_debug_all) else $error("debug command refused");

  property p_rp_block;
    @(posedge clk) disable iff (!rst_n)
      (cmd_start && read_protection_option && byte_data == `DCG_CMD_RD_PMEM)
        |=> (!cmd_allowed && reply_fill);
  endproperty
  a_rp_block: assert property (p_rp_block) else $error("protected read not gated");

  property p_rp_crc;
    @(posedge clk) disable iff (!rst_n)
      (cmd_start && debug_halt_bit && byte_data == `DCG_CMD_CRC) |=> cmd_allowed;
  endproperty
  a_rp_crc: assert property (p_rp_crc) else $error("crc command gated");

  property p_rp_regwr;
    @(posedge clk) disable iff (!rst_n)
      (pay_in && rp_on && cmd_code == `DCG_CMD_WR_REG
        && (reg_addr != `DCG_FLASH_CTL_ADDR || byte_data != `DCG_MASS_ERASE)) |=> !pay_wr;
  endproperty
  a_rp_regwr: assert property (p_rp_regwr) else $error("protected register write passed");

  property p_mass_erase;
    @(posedge clk) disable iff (!rst_n)
      (pay_in && cmd_allowed && rp_on && cmd_code == `DCG_CMD_WR_REG
        && reg_addr == `DCG_FLASH_CTL_ADDR && byte_data == `DCG_MASS_ERASE)
        |=> (pay_wr && pay_data == `DCG_MASS_ERASE);
  endproperty
  a_mass_erase: assert property (p_mass_erase) else $error("mass erase dropped");

  property p_halt_kept;
    @(posedge clk) disable iff (!rst_n)
      (pay_in && read_protection_option && debug_halt_bit && cmd_code == `DCG_CMD_WR_CTL)
        |=> (pay_wr && pay_data[`DCG_HALT_POS]);
  endproperty
  a_halt_kept: assert property (p_halt_kept) else $error("halt bit cleared");

  property p_gated_write;
    @(posedge clk) disable iff (!rst_n)
      (busy && !cmd_allowed) |=> !pay_wr;
  endproperty
  a_gated_write: assert property (p_gated_write) else $error("gated write leaked");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      (cmd_start && !dec_defined) |=> (cmd_reserved && !busy && !cmd_taken && !cpu_step);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte acted on");

  property p_step_gated;
    @(posedge clk) disable iff (!rst_n)
      (cmd_start && byte_data == `DCG_CMD_STEP && !dec_allowed) |=> (!cpu_step && busy);
  endproperty
  a_step_gated: assert property (p_step_gated) else $error("gated step advanced");

endmodule

/* File: logic/dcg_pkg.sv */
// types shared by the debug command gate
package dcg_pkg;
  typedef enum logic [0:0] {
    DCG_IDLE,
    DCG_ACTIVE
  } dcg_state_t;

  // what a decoded command does with its payload
  typedef enum logic [1:0] {
    DCG_KIND_READ,
    DCG_KIND_WRITE,
    DCG_KIND_CPU
  } dcg_kind_t;
endpackage

/* File: verification/dcg_host.sv */
// debug host model: drives the framed byte stream into the gate
`timescale 1ns/100ps

module dcg_host (
  // clock
  input  wire logic        clk,
  // byte stream toward the gate
  output logic             byte_valid,
  output logic             byte_is_cmd,
  output logic [7:0]       byte_data,
  output logic [11:0]      reg_addr,
  output logic             cmd_end
);
  // ==================================================
  // idle lines
  initial begin
    byte_valid  = 1'b0;
    byte_is_cmd = 1'b0;
    byte_data   = 8'h00;
    reg_addr    = 12'h000;
    cmd_end     = 1'b0;
  end

  // one byte per call; released lines show the inverse so stale data never looks valid
  task automatic put(input logic is_cmd, input logic [7:0] data, input logic [11:0] addr);
    @(posedge clk);
    byte_valid  <= 1'b1;
    byte_is_cmd <= is_cmd;
    byte_data   <= data;
    reg_addr    <= addr;
    @(posedge clk);
    byte_valid  <= 1'b0;
    byte_is_cmd <= ~is_cmd;
    byte_data   <= ~data;
    reg_addr    <= ~addr;
  endtask

  // close the open operation, after an optional slow pause
  task automatic close(input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    cmd_end <= 1'b1;
    @(posedge clk);
    cmd_end <= 1'b0;
  endtask
endmodule

/* File: verification/debug_command_gate_bench.sv */
// self-checking bench for the debug command gate
`timescale 1ns/100ps
`include "dcg_cfg.svh"

module debug_command_gate_bench;
  import dcg_pkg::*;
  logic        clk, resetn, debug_halt_bit, read_protection_option;
  logic        byte_valid, byte_is_cmd, cmd_end;
  logic [7:0]  byte_data, cmd_code, pay_data;
  logic [11:0] reg_addr;
  logic        cmd_taken, cmd_allowed, cmd_reserved, busy, reply_fill, pay_wr, cpu_step;
  int          n_mismatch = 0;
  int          checked = 0;

  dcg_host i_dcg_host (.clk(clk), .byte_valid(byte_valid), .byte_is_cmd(byte_is_cmd),
    .byte_data(byte_data), .reg_addr(reg_addr), .cmd_end(cmd_end));

  dcg_gate i_dcg_gate (.clk(clk), .resetn(resetn), .byte_valid(byte_valid),
    .byte_is_cmd(byte_is_cmd), .byte_data(byte_data), .reg_addr(reg_addr),
    .cmd_end(cmd_end), .debug_halt_bit(debug_halt_bit),
    .read_protection_option(read_protection_option), .cmd_taken(cmd_taken),
    .cmd_code(cmd_code), .cmd_allowed(cmd_allowed), .cmd_reserved(cmd_reserved),
    .busy(busy), .reply_fill(reply_fill), .pay_wr(pay_wr), .pay_data(pay_data),
    .cpu_step(cpu_step));

  // ==================================================
  // clock, expectations and compares
  always #5 clk = ~clk;

  function automatic logic allow(input logic [7:0] c, input logic d, input logic p);
    if (!d) return c inside {8'h00, 8'h02, 8'h04, 8'h05};
    if (!p) return 1'b1;
    return !(c inside {8'h06, 8'h07, 8'h09, [8'h0A:8'h0D], [8'h10:8'h12]});
  endfunction

  task automatic chk(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic set_mode(input logic d, input logic p);
    @(posedge clk);
    debug_halt_bit         <= d;
    read_protection_option <= p;
  endtask

  // one payload byte, then judge whether it crossed the gate
  task automatic pay(input logic [7:0] d, input logic [11:0] a, input logic w,
                     input logic [7:0] e);
    i_dcg_host.put(1'b0, d, a);
    #1;
    chk("pay_wr", w, pay_wr);
    if (w) chk8("pay_data", e, pay_data);
  endtask

  // ==================================================
  // scenarios
  // every byte value in all four mode pairs; reads must be filled when gated
  task automatic t_table();
    logic [7:0] c;
    logic       def, ok;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 256; k++) begin
        c = k[7:0];
        def = (c <= 8'h12) && !(c inside {8'h01, 8'h0F});
        ok  = allow(c, m[0], m[1]);
        set_mode(m[0], m[1]);
        i_dcg_host.put(1'b1, c, 12'h000);
        #1;
        chk("cmd_taken", def, cmd_taken);
        chk("cmd_reserved", !def, cmd_reserved);
        chk("busy", def, busy);
        if (def) begin
          chk8("cmd_code", c, cmd_code);
          chk("cmd_allowed", ok, cmd_allowed);
          chk("reply_fill", !ok && (c inside {8'h00, 8'h02, 8'h03, 8'h05, 8'h07, 8'h09,
              8'h0B, 8'h0D, 8'h0E}), reply_fill);
          chk("cpu_step", ok && c == `DCG_CMD_STEP, cpu_step);
          i_dcg_host.close(k % 3);
          #1;
          chk("busy", 1'b0, busy);
          chk("reply_fill", 1'b0, reply_fill);
        end
      end
    end
    $display("test table done");
  endtask

  // register write filter, a gated memory write and an open register write
  task automatic t_write();
    set_mode(1'b1, 1'b1);
    i_dcg_host.put(1'b1, 8'h08, 12'h000);
    pay(`DCG_MASS_ERASE, `DCG_FLASH_CTL_ADDR, 1'b1, `DCG_MASS_ERASE);
    pay(8'h5A, `DCG_FLASH_CTL_ADDR, 1'b0, 8'h00);
    pay(`DCG_MASS_ERASE, 12'h010, 1'b0, 8'h00);
    i_dcg_host.close(2);
    i_dcg_host.put(1'b1, 8'h0C, 12'h000);
    pay(8'h3C, 12'h000, 1'b0, 8'h00);
    i_dcg_host.close(0);
    set_mode(1'b1, 1'b0);
    i_dcg_host.put(1'b1, 8'h08, 12'h000);
    pay(8'hA5, 12'h010, 1'b1, 8'hA5);
    i_dcg_host.close(0);
    $display("test write done");
  endtask

  // halt bit may be set but not cleared while protected
  task automatic t_ctl();
    set_mode(1'b1, 1'b1);
    i_dcg_host.put(1'b1, 8'h04, 12'h000);
    pay(8'h01, 12'h000, 1'b1, 8'h81);
    i_dcg_host.close(0);
    set_mode(1'b1, 1'b0);
    i_dcg_host.put(1'b1, 8'h04, 12'h000);
    pay(8'h00, 12'h000, 1'b1, 8'h00);
    i_dcg_host.close(0);
    $display("test control done");
  endtask

  // stuff and execute: gated ones swallow their bytes, open ones pass them, none steps
  task automatic t_step();
    for (int m = 0; m < 4; m++) begin
      set_mode(1'b1, !m[1]);
      i_dcg_host.put(1'b1, 8'h11 + {7'h00, m[0]}, 12'h000);
      i_dcg_host.put(1'b0, 8'h40, 12'h000);
      #1;
      chk("pay_wr", m[1], pay_wr);
      if (m[1]) chk8("pay_data", 8'h40, pay_data);
      chk("cpu_step", 1'b0, cpu_step);
      chk("busy", 1'b1, busy);
      i_dcg_host.close(0);
      #1;
      chk("busy", 1'b0, busy);
    end
    $display("test step done");
  endtask

  // reset in mid-operation closes it; idle payload is dropped after release
  task automatic t_reset();
    set_mode(1'b1, 1'b0);
    i_dcg_host.put(1'b1, 8'h08, 12'h000);
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    chk("busy", 1'b0, busy);
    chk("cmd_allowed", 1'b0, cmd_allowed);
    chk8("cmd_code", 8'h00, cmd_code);
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    i_dcg_host.put(1'b0, 8'h5A, 12'h000);
    #1;
    chk("pay_wr", 1'b0, pay_wr);
    chk("busy", 1'b0, busy);
    i_dcg_host.put(1'b1, 8'h09, 12'h000);
    #1;
    chk("cmd_taken", 1'b1, cmd_taken);
    chk("cmd_allowed", 1'b1, cmd_allowed);
    i_dcg_host.close(0);
    #1;
    chk("busy", 1'b0, busy);
    $display("test reset done");
  endtask

  // ==================================================
  // verdict, watchdog and main sequence
  task automatic wrap_up();
    $display("counts: checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // about 3.4k cycles expected; a hang costs one mismatch
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    clk                    = 1'b0;
    resetn                 = 1'b0;
    debug_halt_bit         = 1'b0;
    read_protection_option = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_table();
    t_write();
    t_ctl();
    t_step();
    t_reset();
    wrap_up();
  end
endmodule
